// ==== logic/ssp_pkg.sv ====
package ssp_pkg;
  // data path shape
  localparam int SSP_DW = 16;
  localparam int SSP_DEPTH = 8;
  // frame size field holds length minus one; 4 bits is the shortest frame
  localparam logic [3:0] SSP_SIZE_MIN = 4'h3;
  localparam logic [4:0] SSP_WORD_BITS = 5'h10;
  // prescale divisor limits, even values only
  localparam logic [7:0] SSP_PRE_MIN = 8'h02;
  // control-message format: 8 command bits then one turnaround clock
  localparam logic [4:0] SSP_CMD_SKIP = 5'h09;
  // fifo half level used by both service conditions
  localparam logic [3:0] SSP_HALF_LVL = 4'h4;
  // receive timeout, in serial clock periods
  localparam int SSP_TOUT_PERIODS = 32;

  typedef enum logic [1:0] {
    SSP_FMT_SPI,
    SSP_FMT_SSF,
    SSP_FMT_CMSG
  } ssp_fmt_t;

  typedef enum logic [1:0] {
    SSP_M_IDLE,
    SSP_M_SETUP,
    SSP_M_SHIFT,
    SSP_M_END
  } ssp_mst_t;

  typedef struct packed {
    logic enable;
    logic master;
    logic loopback;
    ssp_fmt_t format;
    logic [3:0] frameSize;
    logic clockPolarity;
    logic clockPhase;
    logic [7:0] prescaleDivisor;
    logic [7:0] serialClockRate;
  } ssp_cfg_t;

  typedef struct packed {
    logic overrun;
    logic timeout;
    logic rxService;
    logic txService;
  } ssp_irq_t;
endpackage : ssp_pkg

// ==== logic/ssp_fifo.sv ====
`timescale 1ns/1ps
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [LW-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  // pointers wrap naturally, so the depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("ssp_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [LW-1:0] cnt_r, cnt_nxt;
  logic notFull_r, notFull_nxt, empty_r, empty_nxt;
  logic doWr, doRd;

  assign doWr = inValid & notFull_r;
  assign doRd = outReady & ~empty_r;
  assign inReady = notFull_r;
  assign outValid = ~empty_r;
  assign outData = mem[rdPtr_r];
  assign level = cnt_r;

  // flags are computed ahead so both ends see registered full/empty
  always_comb begin
    wrPtr_nxt = wrPtr_r + AW'(doWr);
    rdPtr_nxt = rdPtr_r + AW'(doRd);
    cnt_nxt = cnt_r + LW'(doWr) - LW'(doRd);
    notFull_nxt = (cnt_nxt != LW'(DEPTH));
    empty_nxt = (cnt_nxt == '0);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
      notFull_r <= 1'b1;
      empty_r <= 1'b1;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      cnt_r <= cnt_nxt;
      notFull_r <= notFull_nxt;
      empty_r <= empty_nxt;
    end
  end

  // storage has no reset, contents are only read behind empty
  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule : ssp_fifo

// ==== logic/ssp_core.sv ====
`timescale 1ns/1ps
// Function
// RQ1: works as master or slave in SPI, pulse-framed and control-message formats
// RQ2: separate transmit and receive fifos, 16 bits by 8 entries
// RQ3: frame length programmable from 4 to 16 bits
// RQ4: loopback feeds own transmit output back to receive input
// RQ5: first rate stage divides by even prescale 2 to 254
// RQ6: second stage divides by one plus serial clock rate field
// RQ7: serial clock equals system clock over prescale times rate plus one
// RQ8: master settings keep system clock at least twice serial clock
// RQ9: external master keeps serial clock at most a twelfth of system clock
// RQ10: data write pushes the word into the transmit fifo
// RQ11: transmit fifo words are serialised onto transmit pin, both roles
// RQ12: data read pops the oldest receive fifo word
// RQ13: received bits gather in a shift register before fifo load
// RQ14: four conditions: tx service, rx service, rx timeout, rx overrun
// RQ15: enabled conditions are ORed into one interrupt request
// RQ16: each condition has a mask bit, 1 lets it through
// RQ17: each condition also has its own output
// RQ18: raw and masked condition state both readable
// RQ19: clock idles between transfers; timeout flags data left waiting
// RQ20: frames go out most significant bit first
// RQ21: clock polarity picks the SPI idle clock level
// RQ22: short frames stored right-justified, upper bits zero
// RQ23: frame ending on full receive fifo is dropped, overrun set
module ssp_core
  import ssp_pkg::*;
#(
  parameter int RX_TOUT_PERIODS = SSP_TOUT_PERIODS,
  parameter int DEPTH = SSP_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ssp_cfg_t cfg,
  input wire ssp_irq_t irqMask,
  input wire logic clrOverrun,
  input wire logic clrTimeout,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [SSP_DW-1:0] wrData,
  input wire logic rdReq,
  output logic rdValid,
  output logic [SSP_DW-1:0] rdData,
  output ssp_irq_t rawStatus,
  output ssp_irq_t maskedStatus,
  output ssp_irq_t irqLines,
  output logic irqCombined,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOeN,
  input wire logic fsIn,
  output logic fsOut,
  output logic fsOeN,
  output logic txdOut,
  output logic txdOeN,
  input wire logic rxdIn
);
  localparam int LW = $clog2(DEPTH + 1);

  if (RX_TOUT_PERIODS < 1 || DEPTH < 2) begin : g_chk
    $error("ssp_core: bad timeout or depth");
  end

  // fifos
  logic txValid, txPop, rxPush, rxReady, rxValid, rxPop;
  logic [SSP_DW-1:0] txData, rxWord, rxHead;
  logic [LW-1:0] txLevel, rxLevel;

  ssp_fifo #(.WIDTH(SSP_DW), .DEPTH(DEPTH)) u_txf ( // RQ2
    .mclk(mclk), .sys_rst(sys_rst),
    .inValid(wrValid), .inReady(wrReady), .inData(wrData), // RQ10
    .outValid(txValid), .outReady(txPop), .outData(txData),
    .level(txLevel));

  ssp_fifo #(.WIDTH(SSP_DW), .DEPTH(DEPTH)) u_rxf ( // RQ2
    .mclk(mclk), .sys_rst(sys_rst),
    .inValid(rxPush), .inReady(rxReady), .inData(rxWord),
    .outValid(rxValid), .outReady(rxPop), .outData(rxHead),
    .level(rxLevel));

  // pin synchronisers: sclk, frame select, receive data
  logic [2:0] syncA_r, syncB_r;
  logic sclkPrev_r, fsPrev_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 3'h2;
      syncB_r <= 3'h2;
      sclkPrev_r <= 1'b0;
      fsPrev_r <= 1'b1;
    end else begin
      syncA_r <= {sclkIn, fsIn, rxdIn};
      syncB_r <= syncA_r;
      sclkPrev_r <= syncB_r[2];
      fsPrev_r <= syncB_r[1];
    end
  end

  // shared frame decode
  logic [4:0] frameLen, rxStart, totalBits, shAmt;
  logic [5:0] lastEdge;
  logic isSpi, isSsf, isCmsg, lateCap, idleClk, rxBit, txdPin_r;
  assign isSpi = (cfg.format == SSP_FMT_SPI);
  assign isSsf = (cfg.format == SSP_FMT_SSF);
  assign isCmsg = (cfg.format == SSP_FMT_CMSG);
  // sizes under 4 bits are raised to 4
  assign frameLen = (cfg.frameSize < SSP_SIZE_MIN) ?
    5'({SSP_SIZE_MIN} + 4'h1) : 5'(cfg.frameSize) + 5'h01; // RQ3
  assign rxStart = isCmsg ? SSP_CMD_SKIP : 5'h00;
  assign totalBits = frameLen + rxStart;
  assign lastEdge = {totalBits, 1'b0} - 6'h01;
  assign shAmt = SSP_WORD_BITS - frameLen;
  // capture on the trailing edge for phase 1 and pulse-framed
  assign lateCap = isSsf | (isSpi & cfg.clockPhase);
  assign idleClk = isSpi & cfg.clockPolarity; // RQ21

  // bit rate generator: half period is prescale/2 * (scr+1) clocks
  logic [6:0] halfDiv, preCnt_r, preCnt_nxt;
  logic [7:0] scrCnt_r, scrCnt_nxt;
  logic halfTick;
  ssp_mst_t mState_r, mState_nxt;
  assign halfDiv = (cfg.prescaleDivisor < SSP_PRE_MIN) ?
    7'h01 : cfg.prescaleDivisor[7:1]; // RQ5
  assign halfTick = (preCnt_r == halfDiv - 7'h01) &&
    (scrCnt_r == cfg.serialClockRate); // RQ6 RQ7

  // held in idle so every frame starts on a fresh half period
  always_comb begin
    preCnt_nxt = preCnt_r + 7'h01;
    scrCnt_nxt = scrCnt_r;
    if (mState_r == SSP_M_IDLE) begin
      preCnt_nxt = 7'h00;
      scrCnt_nxt = 8'h00;
    end else if (preCnt_r >= halfDiv - 7'h01) begin
      preCnt_nxt = 7'h00;
      scrCnt_nxt = halfTick ? 8'h00 : scrCnt_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      preCnt_r <= 7'h00;
      scrCnt_r <= 8'h00;
    end else begin
      preCnt_r <= preCnt_nxt;
      scrCnt_r <= scrCnt_nxt;
    end
  end

  // master sequencer
  logic sclk_r, sclk_nxt, fs_r, fs_nxt, mPush, mPop;
  logic [SSP_DW-1:0] txSh_r, txSh_nxt, rxSh_r, rxSh_nxt, loadWord;
  logic [5:0] edge_r, edge_nxt;
  logic mLead, mCap;
  // control messages send the low byte only; others left-align the frame
  assign loadWord = isCmsg ? {txData[7:0], 8'h00} : (txData << shAmt); // RQ20
  assign mLead = ~edge_r[0];
  assign mCap = lateCap ? ~mLead : mLead;

  always_comb begin
    mState_nxt = mState_r;
    sclk_nxt = sclk_r;
    fs_nxt = fs_r;
    txSh_nxt = txSh_r;
    rxSh_nxt = rxSh_r;
    edge_nxt = edge_r;
    mPush = 1'b0;
    mPop = 1'b0;
    case (mState_r)
      SSP_M_IDLE: begin
        sclk_nxt = idleClk; // RQ19 RQ21
        fs_nxt = ~isSsf;
        edge_nxt = 6'h00;
        if (cfg.enable && cfg.master && txValid) begin // RQ1
          mPop = 1'b1; // RQ11
          txSh_nxt = loadWord;
          rxSh_nxt = '0;
          fs_nxt = isSsf;
          mState_nxt = SSP_M_SETUP;
        end
      end
      SSP_M_SETUP: begin
        // pulse-framed holds its frame pulse for two half periods
        if (halfTick) begin
          if (isSsf && edge_r == 6'h00) begin
            edge_nxt = 6'h01;
          end else begin
            edge_nxt = 6'h00;
            fs_nxt = 1'b0;
            mState_nxt = SSP_M_SHIFT;
          end
        end
      end
      SSP_M_SHIFT: begin
        if (halfTick) begin
          sclk_nxt = ~sclk_r;
          edge_nxt = edge_r + 6'h01;
          if (mCap && edge_r[5:1] >= rxStart) begin
            rxSh_nxt = {rxSh_r[SSP_DW-2:0], rxBit}; // RQ13 RQ22
          end
          if (!mCap && edge_r != 6'h00) begin
            txSh_nxt = {txSh_r[SSP_DW-2:0], 1'b0}; // RQ20
          end
          if (edge_r == lastEdge) begin
            mState_nxt = SSP_M_END;
          end
        end
      end
      SSP_M_END: begin
        if (halfTick) begin
          mPush = 1'b1;
          edge_nxt = 6'h00;
          // phase 1 keeps the select low across back-to-back words
          if (isSpi && cfg.clockPhase && cfg.enable && txValid) begin
            mPop = 1'b1;
            txSh_nxt = loadWord;
            rxSh_nxt = '0;
            mState_nxt = SSP_M_SETUP;
          end else begin
            fs_nxt = ~isSsf;
            mState_nxt = SSP_M_IDLE;
          end
        end
      end
      default: mState_nxt = SSP_M_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mState_r <= SSP_M_IDLE;
      sclk_r <= 1'b0;
      fs_r <= 1'b1;
      txSh_r <= '0;
      rxSh_r <= '0;
      edge_r <= 6'h00;
    end else begin
      mState_r <= mState_nxt;
      sclk_r <= sclk_nxt;
      fs_r <= fs_nxt;
      txSh_r <= txSh_nxt;
      rxSh_r <= rxSh_nxt;
      edge_r <= edge_nxt;
    end
  end

  // slave: edges come from the synchronised clock, hence the 12x margin
  logic sRise, sFall, sLead, sCap, sLaunch, sOn, sActive, fsFall;
  logic sArmed_r, sArmed_nxt, sFresh_r, sFresh_nxt, sPush, sPop, sLoad;
  logic [SSP_DW-1:0] sTx_r, sTx_nxt, sRx_r, sRx_nxt, sLoadWord;
  logic [4:0] sCnt_r, sCnt_nxt;
  assign sRise = syncB_r[2] & ~sclkPrev_r; // RQ9
  assign sFall = ~syncB_r[2] & sclkPrev_r;
  assign sLead = cfg.clockPolarity & isSpi ? sFall : sRise;
  assign sCap = lateCap ? (sRise | sFall) & ~sLead : sLead;
  assign sLaunch = (sRise | sFall) & ~sCap;
  assign fsFall = fsPrev_r & ~syncB_r[1];
  assign sOn = cfg.enable & ~cfg.master;
  assign sActive = sOn & (isSsf ? sArmed_r : ~syncB_r[1]);
  // an empty transmit fifo sends zeros rather than stalling the master
  assign sLoadWord = txValid ? loadWord : '0;

  always_comb begin
    sArmed_nxt = sArmed_r;
    sFresh_nxt = sFresh_r;
    sTx_nxt = sTx_r;
    sRx_nxt = sRx_r;
    sCnt_nxt = sCnt_r;
    sPush = 1'b0;
    sLoad = 1'b0;
    if (!sOn) begin
      sArmed_nxt = 1'b0;
      sCnt_nxt = 5'h00;
    end else if (isSsf && sFall && syncB_r[1]) begin
      sArmed_nxt = 1'b1; // frame pulse seen, bits follow
      sLoad = 1'b1;
    end else if (!isSsf && fsFall) begin
      sLoad = 1'b1;
    end else if (sActive) begin
      if (sRise | sFall) begin
        sFresh_nxt = 1'b0;
      end
      if (sLaunch && !(sFresh_r && lateCap)) begin
        sTx_nxt = {sTx_r[SSP_DW-2:0], 1'b0}; // RQ11 RQ20
      end
      if (sCap) begin
        sCnt_nxt = sCnt_r + 5'h01;
        if (sCnt_r >= rxStart) begin
          sRx_nxt = {sRx_r[SSP_DW-2:0], rxBit}; // RQ13 RQ22
        end
        if (sCnt_r == totalBits - 5'h01) begin
          sPush = 1'b1;
          sCnt_nxt = 5'h00;
          sArmed_nxt = 1'b0;
          // phase 1 frames run on without a select pulse
          sLoad = isSpi & cfg.clockPhase;
        end
      end
    end
    if (sLoad) begin
      sTx_nxt = sLoadWord;
      sFresh_nxt = 1'b1;
      sCnt_nxt = 5'h00;
      if (!sPush) begin
        sRx_nxt = '0;
      end
    end
    if (sPush) begin
      sRx_nxt = '0;
    end
  end
  assign sPop = sLoad & txValid;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sArmed_r <= 1'b0;
      sFresh_r <= 1'b0;
      sTx_r <= '0;
      sRx_r <= '0;
      sCnt_r <= 5'h00;
    end else begin
      sArmed_r <= sArmed_nxt;
      sFresh_r <= sFresh_nxt;
      sTx_r <= sTx_nxt;
      sRx_r <= sRx_nxt;
      sCnt_r <= sCnt_nxt;
    end
  end

  assign txPop = mPop | sPop;
  assign rxPush = mPush | sPush;
  // a slave's last captured bit is not yet in its shift register at push time
  assign rxWord = mPush ? rxSh_r : {sRx_r[SSP_DW-2:0], rxBit};

  // pins, status and read data
  logic [23:0] tout_r, tout_nxt, toutLimit;
  logic ovr_r, ovr_nxt, tmo_r, tmo_nxt, busy;
  logic rdValid_nxt;
  logic [SSP_DW-1:0] rdData_nxt;
  ssp_irq_t raw_nxt, masked_nxt;
  logic sclkPin_nxt, sclkOe_nxt, fsPin_nxt, fsOe_nxt, txdPin_nxt, txdOe_nxt;
  assign toutLimit = 24'(RX_TOUT_PERIODS) * 24'({halfDiv, 1'b0}) *
    24'({1'b0, cfg.serialClockRate} + 9'h001);
  assign busy = (mState_r != SSP_M_IDLE) | sActive;
  assign rxPop = rdReq & rxValid; // RQ12
  // loopback taps the bit ahead of its pin flop so one-clock halves align
  assign rxBit = cfg.loopback ? txdPin_nxt : syncB_r[0]; // RQ4

  always_comb begin
    // overrun and timeout: a new event beats a same-cycle clear
    ovr_nxt = (rxPush & ~rxReady) | (ovr_r & ~clrOverrun); // RQ23
    tmo_nxt = tmo_r & ~clrTimeout;
    tout_nxt = tout_r + 24'h000001;
    if (!rxValid || rxPop || busy) begin
      tout_nxt = 24'h000000;
    end else if (tout_r >= toutLimit) begin
      tout_nxt = tout_r;
      tmo_nxt = 1'b1; // RQ19
    end
    raw_nxt.overrun = ovr_r; // RQ14 RQ18
    raw_nxt.timeout = tmo_r;
    raw_nxt.rxService = (rxLevel >= LW'(SSP_HALF_LVL));
    raw_nxt.txService = (txLevel <= LW'(SSP_HALF_LVL));
    masked_nxt = raw_nxt & irqMask; // RQ16
    rdValid_nxt = rxPop;
    rdData_nxt = rxPop ? rxHead : rdData;
    // master drives clock and select; a slave only drives data in frame
    sclkPin_nxt = cfg.master ? sclk_r : idleClk;
    sclkOe_nxt = ~(cfg.enable & cfg.master);
    fsPin_nxt = cfg.master ? fs_r : 1'b1;
    fsOe_nxt = ~(cfg.enable & cfg.master);
    txdPin_nxt = cfg.master ? txSh_r[SSP_DW-1] : sTx_r[SSP_DW-1];
    if (cfg.master) begin
      txdOe_nxt = ~(cfg.enable & (~isSsf | mState_r != SSP_M_IDLE));
    end else begin
      txdOe_nxt = ~sActive;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ovr_r <= 1'b0;
      tmo_r <= 1'b0;
      tout_r <= 24'h000000;
      rawStatus <= '0;
      maskedStatus <= '0;
      irqLines <= '0;
      irqCombined <= 1'b0;
      rdValid <= 1'b0;
      rdData <= '0;
      sclkOut <= 1'b0;
      sclkOeN <= 1'b1;
      fsOut <= 1'b1;
      fsOeN <= 1'b1;
      txdPin_r <= 1'b0;
      txdOeN <= 1'b1;
    end else begin
      ovr_r <= ovr_nxt;
      tmo_r <= tmo_nxt;
      tout_r <= tout_nxt;
      rawStatus <= raw_nxt;
      maskedStatus <= masked_nxt;
      irqLines <= masked_nxt; // RQ17
      irqCombined <= |masked_nxt; // RQ15
      rdValid <= rdValid_nxt;
      rdData <= rdData_nxt;
      sclkOut <= sclkPin_nxt;
      sclkOeN <= sclkOe_nxt;
      fsOut <= fsPin_nxt;
      fsOeN <= fsOe_nxt;
      txdPin_r <= txdPin_nxt;
      txdOeN <= txdOe_nxt;
    end
  end
  assign txdOut = txdPin_r;
endmodule : ssp_core

// ==== tb/ssp_core_chk.sv ====
`timescale 1ns/1ps
module ssp_core_chk
  import ssp_pkg::*;
#(
  parameter int RX_TOUT_PERIODS = SSP_TOUT_PERIODS,
  parameter int DEPTH = SSP_DEPTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ssp_cfg_t cfg,
  input wire ssp_irq_t irqMask,
  input wire logic clrOverrun,
  input wire logic rdReq,
  input wire logic rdValid,
  input wire ssp_irq_t rawStatus,
  input wire ssp_irq_t maskedStatus,
  input wire ssp_irq_t irqLines,
  input wire logic irqCombined,
  input wire logic sclkOut,
  input wire logic sclkOeN,
  input wire logic fsOut,
  input wire logic fsOeN
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ssp_cfg_t cfg_r;
  logic [2:0] quiet_r, quiet_nxt;
  logic steady;
  // pins lag a config change, so only judge after it has settled
  always_comb begin
    quiet_nxt = quiet_r;
    if (cfg != cfg_r) quiet_nxt = 3'h0;
    else if (quiet_r != 3'h7) quiet_nxt = quiet_r + 3'h1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_r <= 3'h0;
      cfg_r <= '0;
    end else begin
      quiet_r <= quiet_nxt;
      cfg_r <= cfg;
    end
  end
  assign steady = cfg.enable && cfg.master && cfg.format == SSP_FMT_SPI &&
    quiet_r > 3'h3;
  // status and interrupt outputs
  AST_MASK:
    assert property (maskedStatus == (rawStatus & $past(irqMask)))
    else $error("masked status is not raw status and mask");
  AST_LINES:
    assert property (irqLines == maskedStatus)
    else $error("separate lines differ from masked status");
  AST_ANY_SET:
    assert property ((|maskedStatus) |-> ##[0:1] irqCombined)
    else $error("combined request missing");
  AST_ANY_CLR:
    assert property (!(|maskedStatus) [*2] |-> !irqCombined)
    else $error("combined request without a cause");
  AST_RD:
    assert property (rdValid |-> $past(rdReq))
    else $error("read answer without a request");
  AST_OVR:
    assert property (rawStatus.overrun && !clrOverrun && !$past(clrOverrun)
      |=> rawStatus.overrun)
    else $error("overrun dropped without a clear");
  AST_TXS:
    assert property ($fell(sys_rst) |-> ##[0:2] rawStatus.txService)
    else $error("empty transmit fifo not flagged");
  // link pins of an spi master
  AST_IDLE:
    assert property ((steady && fsOut) [*3] |-> sclkOut == cfg.clockPolarity)
    else $error("idle clock level wrong");
  AST_FRAME:
    assert property (steady && !$stable(sclkOut) |-> !fsOut)
    else $error("clock moved outside a frame");
  AST_DRIVE:
    assert property (steady && !fsOut |-> !fsOeN && !sclkOeN)
    else $error("master not driving its frame pins");
  COV_OVR: cover property (rawStatus.overrun);
  COV_CMSG: cover property (cfg.format == SSP_FMT_CMSG && !fsOut);
  COV_RD: cover property (rdReq ##1 rdValid);
endmodule : ssp_core_chk

bind ssp_core ssp_core_chk #(.RX_TOUT_PERIODS(RX_TOUT_PERIODS), .DEPTH(DEPTH))
  u_chk (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .irqMask(irqMask),
  .clrOverrun(clrOverrun), .rdReq(rdReq), .rdValid(rdValid),
  .rawStatus(rawStatus), .maskedStatus(maskedStatus), .irqLines(irqLines),
  .irqCombined(irqCombined), .sclkOut(sclkOut), .sclkOeN(sclkOeN),
  .fsOut(fsOut), .fsOeN(fsOeN));

// ==== tb/ssp_spi_slave.sv ====
`timescale 1ns/1ps
// far-side slave, mode 0, replies msb first
module ssp_spi_slave (
  input wire logic sclk,
  input wire logic fsN,
  input wire logic mosi,
  input wire logic [4:0] nBits,
  input wire logic [15:0] respWord,
  output logic miso,
  output logic [15:0] gotWord
);
  int idx = 0;
  // a new frame reloads the pointer and clears what was heard
  always @(negedge fsN) begin
    idx = int'(nBits) - 1;
    gotWord = 16'h0000;
  end
  // master data taken on the rising edge
  always @(posedge sclk) begin
    if (!fsN) gotWord = {gotWord[14:0], mosi};
  end
  // next reply bit after each falling edge
  always @(negedge sclk) begin
    if (!fsN && idx > 0) idx = idx - 1;
  end
  // a deselected line shows the inverse, never a stale copy
  assign miso = fsN ? ~respWord[0] : respWord[idx];
endmodule : ssp_spi_slave

// ==== tb/synchronous_serial_port_tb.sv ====
`timescale 1ns/1ps
module synchronous_serial_port_tb;
  import ssp_pkg::*;
  // short receive timeout keeps idle waits brief
  localparam int TOUT = 1;
  logic mclk, sys_rst, clrOverrun, clrTimeout, wrValid, wrReady, rdReq;
  logic rdValid, irqCombined, sclkOut, sclkOeN, fsOut, fsOeN, txdOut, txdOeN;
  logic sclkPin, fsPin, txdPin, rxdPin, mSclk = 1'b0, mFs = 1'b1;
  logic [15:0] wrData, rdData, respWord, gotWord;
  logic [4:0] slvBits;
  ssp_cfg_t cfg;
  ssp_irq_t irqMask, rawStatus, maskedStatus, irqLines;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  // released clock and select are driven by the bench as master
  assign sclkPin = sclkOeN ? mSclk : sclkOut;
  assign fsPin = fsOeN ? mFs : fsOut;
  assign txdPin = txdOeN ? 1'b1 : txdOut;
  ssp_core #(.RX_TOUT_PERIODS(TOUT)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .irqMask(irqMask),
    .clrOverrun(clrOverrun), .clrTimeout(clrTimeout), .wrValid(wrValid),
    .wrReady(wrReady), .wrData(wrData), .rdReq(rdReq), .rdValid(rdValid),
    .rdData(rdData), .rawStatus(rawStatus), .maskedStatus(maskedStatus),
    .irqLines(irqLines), .irqCombined(irqCombined), .sclkIn(sclkPin),
    .sclkOut(sclkOut), .sclkOeN(sclkOeN), .fsIn(fsPin), .fsOut(fsOut),
    .fsOeN(fsOeN), .txdOut(txdOut), .txdOeN(txdOeN), .rxdIn(rxdPin));
  ssp_spi_slave u_slave (.sclk(sclkPin), .fsN(fsPin), .mosi(txdPin),
    .nBits(slvBits), .respWord(respWord), .miso(rxdPin), .gotWord(gotWord));
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      $display("[FAIL] watchdog expected 0 seen %0d", cyc);
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic cmp16(input string s, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp16
  task automatic cmp1(input string s, input logic e, input logic g);
    cmp16(s, {15'h0000, e}, {15'h0000, g});
  endtask : cmp1
  function automatic logic [15:0] lenMask(input logic [3:0] sz);
    return 16'hffff >> (4'hf - sz);
  endfunction : lenMask
  // caller drops wrValid after the last word
  task automatic push(input logic [15:0] w);
    wrValid = 1'b1;
    wrData = w;
    for (int i = 0; i < 9000 && wrReady !== 1'b1; i++) step(1);
    step(1);
  endtask : push
  // pulse a read every other cycle; empty reads are simply refused
  task automatic pop(input logic [15:0] e);
    for (int i = 0; i < 9000; i++) begin
      rdReq = 1'b1;
      step(1);
      rdReq = 1'b0;
      if (rdValid === 1'b1) break;
      step(1);
    end
    cmp16("rdData", e, rdData);
    step(1);
  endtask : pop
  task automatic setup(input ssp_fmt_t f, input logic [3:0] sz,
    input logic [7:0] pre, input logic [7:0] serial_clock_rate_field, input logic lb,
    input logic pol, input logic pha);
    cfg = '{enable: 1'b1, master: 1'b1, loopback: lb, format: f,
      frameSize: sz, clockPolarity: pol, clockPhase: pha,
      prescaleDivisor: pre, serialClockRate: serial_clock_rate_field};
    step(4);
  endtask : setup
  task automatic t_reset();
    cmp1("sclkOeN", 1'b1, sclkOeN);
    cmp1("txdOeN", 1'b1, txdOeN);
    cmp1("fsOut", 1'b1, fsOut);
    step(1);
    sys_rst = 1'b0;
    step(2);
    cmp1("wrReady", 1'b1, wrReady);
    cmp16("rawStatus", 16'h0001, {12'h000, rawStatus});
    $display("t_reset done");
  endtask : t_reset
  // loopback, every spi mode then the pulse-framed format
  task automatic t_loop();
    logic [3:0] sz [5] = '{4'hf, 4'h3, 4'h7, 4'hb, 4'h9};
    logic [15:0] w;
    for (int i = 0; i < 5; i++) begin
      w = 16'hc5a9 + 16'(i);
      setup(i < 4 ? SSP_FMT_SPI : SSP_FMT_SSF, sz[i], 8'h02, 8'h00, 1'b1,
        i[1], i[0]);
      push(w);
      push(~w);
      wrValid = 1'b0;
      pop(w & lenMask(sz[i]));
      pop(~w & lenMask(sz[i]));
      if (i < 4) cmp1("sclkOut", i[1], sclkOut);
    end
    $display("t_loop done");
  endtask : t_loop
  // real slave; rates keep mclk well above twice sclk
  task automatic t_link();
    ssp_fmt_t fm [5] = '{SSP_FMT_SPI, SSP_FMT_SPI, SSP_FMT_CMSG, SSP_FMT_SPI,
      SSP_FMT_SPI};
    logic [3:0] sz [5] = '{4'h7, 4'h3, 4'h3, 4'hf, 4'h3};
    logic [7:0] pre [5] = '{8'h08, 8'h0c, 8'h04, 8'hfe, 8'h02};
    logic [7:0] serial_clock_rate_field [5] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'hff};
    logic [15:0] w, m, got;
    int n;
    for (int i = 0; i < 5; i++) begin
      w = 16'h9a5c + 16'(i);
      m = lenMask(sz[i]);
      respWord = 16'hb3c6 - 16'(i);
      slvBits = 5'(sz[i]) + (fm[i] == SSP_FMT_CMSG ? 5'h0a : 5'h01);
      setup(fm[i], sz[i], pre[i], serial_clock_rate_field[i], 1'b0, 1'b0, 1'b0);
      push(w);
      wrValid = 1'b0;
      n = 0;
      for (int k = 0; k < 9000 && sclkPin !== 1'b1; k++) step(1);
      while (sclkPin !== 1'b0 && n < 9000) begin
        step(1);
        n++;
      end
      while (sclkPin !== 1'b1 && n < 9000) begin
        step(1);
        n++;
      end
      cmp16("period", 16'(pre[i]) * (16'(serial_clock_rate_field[i]) + 16'h1), 16'(n));
      pop(respWord & m);
      got = fm[i] == SSP_FMT_CMSG ? (gotWord >> (sz[i] + 4'h2)) & 16'h00ff
        : gotWord & m;
      cmp16("sent", fm[i] == SSP_FMT_CMSG ? w & 16'h00ff : w & m, got);
    end
    $display("t_link done");
  endtask : t_link
  // bench clocks the slave role at mclk/16, inside the margin
  task automatic t_slave();
    respWord = 16'h6e35;
    slvBits = 5'h08;
    setup(SSP_FMT_SPI, 4'h7, 8'h02, 8'h00, 1'b0, 1'b0, 1'b0);
    cfg.master = 1'b0;
    push(16'h00a7);
    wrValid = 1'b0;
    mFs = 1'b0;
    repeat (16) begin
      step(8);
      mSclk = ~mSclk;
    end
    step(8);
    mFs = 1'b1;
    pop(16'h0035);
    cmp16("slaveSent", 16'h00a7, gotWord);
    $display("t_slave done");
  endtask : t_slave
  // fill tx while stopped, then overrun rx by one word
  task automatic t_fill();
    setup(SSP_FMT_SPI, 4'hf, 8'h02, 8'h00, 1'b1, 1'b0, 1'b0);
    cfg.enable = 1'b0;
    irqMask = 4'h8;
    for (int i = 0; i < 8; i++) push(16'h0f00 + 16'(i));
    wrValid = 1'b0;
    step(2);
    cmp1("wrReady", 1'b0, wrReady);
    cmp1("txService", 1'b0, rawStatus.txService);
    cfg.enable = 1'b1;
    push(16'h0f08);
    wrValid = 1'b0;
    for (int i = 0; i < 9000 && rawStatus.overrun !== 1'b1; i++) step(1);
    step(10);
    cmp16("rawStatus", 16'h000f, {12'h000, rawStatus});
    cmp16("masked", 16'h0008, {12'h000, maskedStatus});
    cmp16("irqLines", 16'h0008, {12'h000, irqLines});
    cmp1("irqCombined", 1'b1, irqCombined);
    irqMask = 4'h0;
    step(3);
    cmp1("irqCombined", 1'b0, irqCombined);
    for (int i = 0; i < 8; i++) pop(16'h0f00 + 16'(i));
    clrOverrun = 1'b1;
    clrTimeout = 1'b1;
    step(1);
    clrOverrun = 1'b0;
    clrTimeout = 1'b0;
    step(6);
    cmp16("rawStatus", 16'h0001, {12'h000, rawStatus});
    $display("t_fill done");
  endtask : t_fill
  // main sequence
  initial begin
    sys_rst = 1'b1;
    cfg = '0;
    irqMask = 4'h0;
    clrOverrun = 1'b0;
    clrTimeout = 1'b0;
    wrValid = 1'b0;
    wrData = 16'h0000;
    rdReq = 1'b0;
    respWord = 16'h0000;
    slvBits = 5'h08;
    repeat (19) @(posedge mclk);
    #1;
    t_reset();
    t_loop();
    t_link();
    t_slave();
    t_fill();
    finish_test();
  end
endmodule : synchronous_serial_port_tb
